// ==== hw/sar_control.sv ====
`timescale 1ns/1ps
`default_nettype none
module sar_control (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [9:0] sar_code_i,
  output logic converter_enable_o,
  output logic track_o,
  output logic sample_hold_o,
  output logic [4:0] pos_mux_o,
  output logic [4:0] neg_mux_o,
  output logic temp_sensor_en_o,
  output logic diff_mode_o,
  output logic irq_o
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [4:0] pos_sel;
    logic [4:0] neg_sel;
    logic [4:0] div;
    logic [7:0] res_high;
    logic [7:0] res_low;
    logic irq_stat;
    logic irq_mask;
    sar_pkg::conv_state_e state;
    logic [3:0] cnt;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic track;
    logic hold;
    logic temp_en;
    logic irq;
    logic diff;
  } ctl_s;
  ctl_s st_reg;
  ctl_s st_next;

  logic tick;
  logic run;
  logic diff;
  logic [7:0] fmt_high;
  logic [7:0] fmt_low;
  logic access;
  logic wr;
  logic done_evt;

  assign access = psel && penable && !st_reg.ready;
  // writes land on the edge where the master sees pready high, not one edge early
  assign wr = psel && penable && pwrite && st_reg.ready;
  // registered mode flag, updated in the same edge as the negative select
  assign diff = st_reg.diff;
  assign run = st_reg.ctrl[sar_pkg::EN_POS] && (st_reg.state != sar_pkg::IDLE);

  // divider restarts per conversion for a fixed track window
  clk_divider u_div (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .run_i(run),
    .div_i(st_reg.div),
    .tick_o(tick)
  );

  // formatting uses the alignment bit as it stands at completion
  result_formatter u_fmt (
    .code_i(sar_code_i),
    .diff_i(diff),
    .left_i(st_reg.ctrl[sar_pkg::LJST_POS]),
    .high_o(fmt_high),
    .low_o(fmt_low)
  );

  assign done_evt = (st_reg.state == sar_pkg::CONVERT) && tick && (st_reg.cnt == 4'h1);

  // bus, conversion sequencer and interrupt in one next-state process
  always_comb
  begin
    st_next = st_reg;
    st_next.ready = 1'b0;
    st_next.slverr = 1'b0;
    // register writes
    if (wr)
    begin
      unique case (paddr)
        sar_pkg::CTRL_OFFS:
        begin
          st_next.ctrl[sar_pkg::EN_POS] = pwdata[sar_pkg::EN_POS];
          st_next.ctrl[sar_pkg::TRACK_POS] = pwdata[sar_pkg::TRACK_POS];
          st_next.ctrl[sar_pkg::LJST_POS] = pwdata[sar_pkg::LJST_POS];
          if (!pwdata[sar_pkg::DONE_POS])
            st_next.ctrl[sar_pkg::DONE_POS] = 1'b0;
        end
        sar_pkg::POS_SEL_OFFS: st_next.pos_sel = pwdata[4:0];
        sar_pkg::NEG_SEL_OFFS: st_next.neg_sel = pwdata[4:0];
        sar_pkg::CFG_OFFS: st_next.div = pwdata[4:0];
        sar_pkg::IRQ_STAT_OFFS:
          if (pwdata[sar_pkg::IRQ_DONE_POS])
            st_next.irq_stat = 1'b0;
        sar_pkg::IRQ_MASK_OFFS: st_next.irq_mask = pwdata[sar_pkg::IRQ_DONE_POS];
        sar_pkg::RES_HIGH_OFFS, sar_pkg::RES_LOW_OFFS: ;
        default: ; // error already flagged on pslverr
      endcase
    end
    // register reads
    if (access)
    begin
      st_next.ready = 1'b1;
      st_next.rdata = 32'h0000_0000;
      unique case (paddr)
        sar_pkg::CTRL_OFFS: st_next.rdata[7:0] = st_reg.ctrl;
        sar_pkg::POS_SEL_OFFS: st_next.rdata[4:0] = st_reg.pos_sel;
        sar_pkg::NEG_SEL_OFFS: st_next.rdata[4:0] = st_reg.neg_sel;
        sar_pkg::CFG_OFFS: st_next.rdata[4:0] = st_reg.div;
        sar_pkg::RES_HIGH_OFFS: st_next.rdata[7:0] = st_reg.res_high;
        sar_pkg::RES_LOW_OFFS: st_next.rdata[7:0] = st_reg.res_low;
        sar_pkg::IRQ_STAT_OFFS: st_next.rdata[0] = st_reg.irq_stat;
        sar_pkg::IRQ_MASK_OFFS: st_next.rdata[0] = st_reg.irq_mask;
        default: st_next.slverr = 1'b1; // unmapped read or write
      endcase
    end
    // conversion sequencer
    unique case (st_reg.state)
      sar_pkg::IDLE:
        if (wr && paddr == sar_pkg::CTRL_OFFS && pwdata[sar_pkg::BUSY_POS]
            && st_reg.ctrl[sar_pkg::EN_POS] && pwdata[sar_pkg::EN_POS])
        begin
          st_next.ctrl[sar_pkg::BUSY_POS] = 1'b1;
          // tracking mode written together with the start applies at once
          if (pwdata[sar_pkg::TRACK_POS])
          begin
            st_next.state = sar_pkg::TRACK;
            st_next.cnt = sar_pkg::TRACK_CLKS;
          end
          else
          begin
            st_next.state = sar_pkg::CONVERT;
            st_next.cnt = sar_pkg::CONV_BITS;
          end
        end
      sar_pkg::TRACK:
        if (tick)
        begin
          st_next.cnt = st_reg.cnt - 4'h1;
          if (st_reg.cnt == 4'h1)
          begin
            st_next.state = sar_pkg::CONVERT;
            st_next.cnt = sar_pkg::CONV_BITS;
          end
        end
      sar_pkg::CONVERT:
        if (tick)
        begin
          st_next.cnt = st_reg.cnt - 4'h1;
          if (done_evt)
          begin
            st_next.state = sar_pkg::IDLE;
            st_next.ctrl[sar_pkg::BUSY_POS] = 1'b0;
            st_next.ctrl[sar_pkg::DONE_POS] = 1'b1; // set wins over clear
            st_next.irq_stat = 1'b1;
            st_next.res_high = fmt_high; // held until next completion
            st_next.res_low = fmt_low;
          end
        end
      default: st_next.state = sar_pkg::IDLE; // unused code falls back to idle
    endcase
    // disabling aborts the conversion, results kept
    if (!st_next.ctrl[sar_pkg::EN_POS])
    begin
      st_next.state = sar_pkg::IDLE;
      st_next.ctrl[sar_pkg::BUSY_POS] = 1'b0;
    end
    // tracking: continuous unless low-power mode, never while converting
    st_next.track = st_next.ctrl[sar_pkg::EN_POS] && (st_next.state != sar_pkg::CONVERT)
      && (!st_next.ctrl[sar_pkg::TRACK_POS] || st_next.state == sar_pkg::TRACK);
    st_next.hold = (st_next.state == sar_pkg::CONVERT);
    st_next.temp_en = st_next.ctrl[sar_pkg::EN_POS]
      && (st_next.pos_sel == sar_pkg::POS_TEMP);
    st_next.irq = st_next.irq_stat && st_next.irq_mask;
    // single-ended only when ground is the negative input
    st_next.diff = (st_next.neg_sel != sar_pkg::NEG_GND);
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      st_reg <= '0;
      st_reg.ctrl <= sar_pkg::CTRL_RST;
      st_reg.pos_sel <= sar_pkg::SEL_RST;
      st_reg.neg_sel <= sar_pkg::SEL_RST;
      st_reg.div <= sar_pkg::DIV_RST;
      st_reg.state <= sar_pkg::IDLE;
      st_reg.diff <= 1'b1; // reset select is a port, so differential
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // pure flop outputs
  assign prdata = st_reg.rdata;
  assign pready = st_reg.ready;
  assign pslverr = st_reg.slverr;
  assign converter_enable_o = st_reg.ctrl[sar_pkg::EN_POS];
  assign track_o = st_reg.track;
  assign sample_hold_o = st_reg.hold;
  assign pos_mux_o = st_reg.pos_sel;
  assign neg_mux_o = st_reg.neg_sel;
  assign temp_sensor_en_o = st_reg.temp_en;
  assign diff_mode_o = st_reg.diff;
  assign irq_o = st_reg.irq;
endmodule : sar_control
`default_nettype wire

// ==== pkg/sar_pkg.sv ====
package sar_pkg;
  // register byte addresses on apb
  localparam logic [7:0] CTRL_OFFS = 8'h00;
  localparam logic [7:0] POS_SEL_OFFS = 8'h04;
  localparam logic [7:0] NEG_SEL_OFFS = 8'h08;
  localparam logic [7:0] CFG_OFFS = 8'h0c;
  localparam logic [7:0] RES_HIGH_OFFS = 8'h10;
  localparam logic [7:0] RES_LOW_OFFS = 8'h14;
  localparam logic [7:0] IRQ_STAT_OFFS = 8'h18;
  localparam logic [7:0] IRQ_MASK_OFFS = 8'h1c;
  // control register fields
  localparam int LJST_POS = 0;
  localparam int TRACK_POS = 6;
  localparam int BUSY_POS = 4;
  localparam int DONE_POS = 5;
  localparam int EN_POS = 7;
  // irq status fields
  localparam int IRQ_DONE_POS = 0;
  // select encodings
  localparam logic [4:0] SEL_LAST_PORT = 5'h14;
  localparam logic [4:0] POS_TEMP = 5'h1e;
  localparam logic [4:0] POS_SUPPLY = 5'h1f;
  localparam logic [4:0] NEG_REF = 5'h1e;
  localparam logic [4:0] NEG_GND = 5'h1f;
  localparam int NUM_SELECTIONS = 23;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [4:0] SEL_RST = 5'h00;
  localparam logic [4:0] DIV_RST = 5'h1f;
  // timing in conversion clocks
  localparam logic [3:0] TRACK_CLKS = 4'h3;
  localparam logic [3:0] CONV_BITS = 4'ha;
  typedef enum logic [1:0] {IDLE, TRACK, CONVERT} conv_state_e;
endpackage : sar_pkg

// ==== hw/clk_divider.sv ====
`timescale 1ns/1ps
`default_nettype none
// one-cycle enable at clk / (div + 1)
module clk_divider (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [4:0] div_i,
  output logic tick_o
);
  typedef struct packed {
    logic [4:0] cnt;
    logic tick;
  } div_s;
  div_s st_reg;
  div_s st_next;

  // count restarts whenever run is low so every conversion is aligned
  always_comb
  begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (!run_i)
    begin
      st_next.cnt = 5'h00;
    end
    else if (st_reg.cnt >= div_i)
    begin
      st_next.cnt = 5'h00;
      st_next.tick = 1'b1;
    end
    else
    begin
      st_next.cnt = st_reg.cnt + 5'h01;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign tick_o = st_reg.tick;
endmodule : clk_divider
`default_nettype wire

// ==== hw/result_formatter.sv ====
`timescale 1ns/1ps
`default_nettype none
// packs a 10-bit code into high and low result bytes
module result_formatter (
  input wire logic [9:0] code_i,
  input wire logic diff_i,
  input wire logic left_i,
  output logic [7:0] high_o,
  output logic [7:0] low_o
);
  logic [15:0] word;

  // alignment, sign extension and zero fill
  always_comb
  begin
    word = 16'h0000;
    if (left_i)
      word = {code_i, 6'h00};
    else if (diff_i)
      word = {{6{code_i[9]}}, code_i};
    else
      word = {6'h00, code_i};
  end

  assign high_o = word[15:8];
  assign low_o = word[7:0];
endmodule : result_formatter
`default_nettype wire

// ==== bench/sar_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module sar_checker (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic converter_enable_o,
  input wire logic track_o,
  input wire logic sample_hold_o,
  input wire logic [4:0] pos_mux_o,
  input wire logic [4:0] neg_mux_o,
  input wire logic temp_sensor_en_o,
  input wire logic diff_mode_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // mode and routing follow the select registers
  AST_DIFF: assert property (diff_mode_o == (neg_mux_o != sar_pkg::NEG_GND))
    else $error("mode does not follow negative select");
  AST_TEMP: assert property ((converter_enable_o && pos_mux_o == sar_pkg::POS_TEMP) [*2]
    |-> temp_sensor_en_o)
    else $error("sensor not routed");
  // two cycles allowed, since outputs are registered
  AST_SHUT: assert property (!converter_enable_o [*2] |-> !track_o && !sample_hold_o)
    else $error("activity while disabled");
  AST_EXCL: assert property (!(track_o && sample_hold_o))
    else $error("tracking during conversion");
  // hold checked for eight clocks; a conversion is ten ticks of at least one clock each
  AST_CONV: assert property ($rose(sample_hold_o) |-> sample_hold_o [*8])
    else $error("conversion too short");
  AST_RDY: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after access");
  AST_PULSE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_HOLD: assert property (!(psel && pwrite) |=> $stable(pos_mux_o)
    && $stable(neg_mux_o) && $stable(converter_enable_o))
    else $error("select changed without write");
endmodule : sar_checker
bind sar_control sar_checker chk (.clk_sys_i, .rst_i, .psel, .penable, .pwrite, .pready,
  .pslverr, .converter_enable_o, .track_o, .sample_hold_o, .pos_mux_o, .neg_mux_o,
  .temp_sensor_en_o, .diff_mode_o);
`default_nettype wire

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys_i, rst_i, psel, penable, pwrite, pready, pslverr, slv;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [9:0] sar_code_i;
  logic converter_enable_o, track_o, sample_hold_o, temp_sensor_en_o, diff_mode_o, irq_o;
  logic [4:0] pos_mux_o, neg_mux_o;
  int err_total, check_count, cyc;
  logic [9:0] codes [10] = '{10'h3ff, 10'h3ff, 10'h200, 10'h100, 10'h1ff, 10'h1ff,
    10'h200, 10'h200, 10'h300, 10'h300};
  logic [15:0] exps [10] = '{16'h03ff, 16'hffc0, 16'h0200, 16'h4000, 16'h01ff, 16'h7fc0,
    16'hfe00, 16'h8000, 16'hff00, 16'hc000};
  sar_control uut (.clk_sys_i, .rst_i, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .sar_code_i, .converter_enable_o, .track_o, .sample_hold_o,
    .pos_mux_o, .neg_mux_o, .temp_sensor_en_o, .diff_mode_o, .irq_o);
  // 10 mhz system clock
  initial
  begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // one apb transfer; held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    // no own limit: the hang guard ends a stuck wait
    do
      @(posedge clk_sys_i);
    while (pready !== 1'b1);
    q = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys_i);
  endtask : apb
  // start, then poll the done flag under a bound
  task automatic conv(input logic [7:0] ctl, input logic [9:0] code);
    int n;
    n = 0;
    sar_code_i <= code;
    apb(1'b1, sar_pkg::CTRL_OFFS, {24'h0, ctl});
    do
    begin
      apb(1'b0, sar_pkg::CTRL_OFFS, 32'h0);
      n++;
    end
    while (q[sar_pkg::DONE_POS] !== 1'b1 && n < 40);
    chk(q[sar_pkg::DONE_POS], 1'b1);
    chk(q[sar_pkg::BUSY_POS], 1'b0);
  endtask : conv
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  // hang guard
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      complete_run();
    end
  end
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, sar_code_i} = '0;
    rst_i = 1'b1;
    repeat (20) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    apb(1'b0, sar_pkg::CFG_OFFS, 32'h0);
    chk(q, 32'h1f);
    apb(1'b0, sar_pkg::RES_HIGH_OFFS, 32'h0);
    chk(q, 32'h0);
    apb(1'b1, sar_pkg::RES_HIGH_OFFS, 32'hff);
    apb(1'b0, sar_pkg::RES_HIGH_OFFS, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk(slv, 1'b1);
    apb(1'b1, 8'h40, 32'hff);
    chk(slv, 1'b1);
    chk(diff_mode_o, 1'b1);
    chk(converter_enable_o, 1'b0);
    $display("test reset done");
    // fastest divider keeps conversions short
    apb(1'b1, sar_pkg::CFG_OFFS, 32'h0);
    apb(1'b1, sar_pkg::IRQ_MASK_OFFS, 32'h1);
    apb(1'b1, sar_pkg::CTRL_OFFS, 32'h80);
    apb(1'b1, sar_pkg::POS_SEL_OFFS, {27'h0, sar_pkg::POS_TEMP});
    repeat (2) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk(temp_sensor_en_o, 1'b1);
    chk(converter_enable_o, 1'b1);
    @(posedge clk_sys_i);
    apb(1'b1, sar_pkg::POS_SEL_OFFS, {27'h0, sar_pkg::POS_SUPPLY});
    chk(pos_mux_o, sar_pkg::POS_SUPPLY);
    chk(temp_sensor_en_o, 1'b0);
    $display("test select done");
    // both alignments, both modes, both tracking modes
    for (int i = 0; i < 10; i++)
    begin
      apb(1'b1, sar_pkg::NEG_SEL_OFFS, {27'h0, i < 4 ? sar_pkg::NEG_GND :
        (i == 8 ? 5'h05 : sar_pkg::NEG_REF)});
      chk(diff_mode_o, i >= 4);
      conv({1'b1, i[1], 2'b01, 3'b000, i[0]}, codes[i]);
      apb(1'b0, sar_pkg::RES_HIGH_OFFS, 32'h0);
      chk(q, {24'h0, exps[i][15:8]});
      apb(1'b0, sar_pkg::RES_LOW_OFFS, 32'h0);
      chk(q, {24'h0, exps[i][7:0]});
      chk(track_o, !i[1]);
      chk(irq_o, 1'b1);
      apb(1'b1, sar_pkg::IRQ_STAT_OFFS, 32'h1);
      @(negedge clk_sys_i);
      chk(irq_o, 1'b0);
      @(posedge clk_sys_i);
    end
    $display("test format done");
    // alignment change and new code must not touch the held result
    sar_code_i <= 10'h0aa;
    apb(1'b1, sar_pkg::CTRL_OFFS, 32'h80);
    apb(1'b0, sar_pkg::RES_HIGH_OFFS, 32'h0);
    chk(q, 32'hc0);
    apb(1'b0, sar_pkg::RES_LOW_OFFS, 32'h0);
    chk(q, 32'h0);
    apb(1'b1, sar_pkg::IRQ_MASK_OFFS, 32'h0);
    conv(8'h90, 10'h155);
    apb(1'b0, sar_pkg::RES_HIGH_OFFS, 32'h0);
    chk(q, 32'h01);
    apb(1'b0, sar_pkg::RES_LOW_OFFS, 32'h0);
    chk(q, 32'h55);
    chk(irq_o, 1'b0);
    apb(1'b0, sar_pkg::IRQ_STAT_OFFS, 32'h0);
    chk(q, 32'h1);
    apb(1'b1, sar_pkg::IRQ_MASK_OFFS, 32'h1);
    @(negedge clk_sys_i);
    chk(irq_o, 1'b1);
    @(posedge clk_sys_i);
    apb(1'b1, sar_pkg::CTRL_OFFS, 32'h0);
    @(negedge clk_sys_i);
    chk(converter_enable_o, 1'b0);
    @(posedge clk_sys_i);
    $display("test hold and mask done");
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
